// *** src/cimc_pkg.sv ***
package cimc_pkg;

	// ----------------------------------------------------------------
	// Machine cycle timing
	// ----------------------------------------------------------------
	localparam int unsigned CLOCKS_PER_MC = 4;
	localparam logic [1:0] PHASE_FIRST = 2'h0;
	localparam logic [1:0] PHASE_FOURTH = 2'(CLOCKS_PER_MC - 1);

	// ----------------------------------------------------------------
	// Reset qualification and stretching, in machine cycles
	// ----------------------------------------------------------------
	localparam logic [1:0] EXT_RST_MIN_MC = 2'h2;
	localparam logic [1:0] EXT_RST_HOLD_MC = 2'h2;
	localparam logic [1:0] WDT_RST_HOLD_MC = 2'h2;
	localparam logic [1:0] MC_COUNT_ZERO = 2'h0;

	// ----------------------------------------------------------------
	// Watchdog reset delay after a time-out, in clock periods
	// ----------------------------------------------------------------
	localparam int unsigned WDT_RESET_DELAY_CLK = 512;
	localparam logic [9:0] WDT_DELAY_LOAD = 10'(WDT_RESET_DELAY_CLK - 1);
	localparam logic [9:0] WDT_DELAY_ZERO = 10'h000;
	localparam logic [3:0] WDT_HOLD_LOAD = 4'(WDT_RST_HOLD_MC * CLOCKS_PER_MC - 1);
	localparam logic [3:0] WDT_HOLD_ZERO = 4'h0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] PC_RESET_VECTOR = 16'h0000;
	localparam logic [7:0] PORT_RESET_VALUE = 8'hff;
	localparam logic STROBE_IDLE_LEVEL = 1'b1;

	// ----------------------------------------------------------------
	// Power state
	// ----------------------------------------------------------------
	typedef enum logic {
		CIMC_RUN,
		CIMC_IDLE
	} cimc_state_t;

endpackage : cimc_pkg

// *** src/cimc_seq_if.sv ***
interface cimc_seq_if;
	logic fourth_clock_state;
	logic ext_rst_active;
	logic [1:0] phase;

	modport timing (
		output fourth_clock_state,
		output ext_rst_active,
		output phase
	);

	modport ctrl (
		input fourth_clock_state,
		input ext_rst_active,
		input phase
	);
endinterface : cimc_seq_if

// *** src/cimc_cycle_timer.sv ***
module cimc_cycle_timer
	import cimc_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic ext_reset_pin,
	cimc_seq_if.timing seq
);

	// ----------------------------------------------------------------
	// State phase counter and pin qualifier
	// ----------------------------------------------------------------
	logic [1:0] phase_ff;
	logic [1:0] nxt_phase;
	logic [1:0] high_cnt_ff;
	logic [1:0] nxt_high_cnt;
	logic [1:0] hold_cnt_ff;
	logic [1:0] nxt_hold_cnt;
	logic active_ff;
	logic nxt_active;
	logic at_fourth;

	// Phase walks the four clock states; the pin is only looked at in the last one.
	always_comb begin
		at_fourth = (phase_ff == PHASE_FOURTH); // RL16
		nxt_phase = at_fourth ? PHASE_FIRST : phase_ff + 2'h1; // RL16
		nxt_high_cnt = high_cnt_ff;
		nxt_hold_cnt = hold_cnt_ff;
		nxt_active = active_ff;
		if (at_fourth) begin
			if (ext_reset_pin) begin
				// Count consecutive high samples, saturating at the minimum.
				if (high_cnt_ff != EXT_RST_MIN_MC) begin
					nxt_high_cnt = high_cnt_ff + 2'h1; // RL17
				end
				if (high_cnt_ff + 2'h1 >= EXT_RST_MIN_MC) begin
					nxt_active = 1'b1; // RL10
					nxt_hold_cnt = EXT_RST_HOLD_MC;
				end
			end else begin
				nxt_high_cnt = MC_COUNT_ZERO;
				// Reset stays applied until the second low sample, one machine cycle after the first low sample.
				if (active_ff) begin
					if (hold_cnt_ff == 2'h1 || hold_cnt_ff == MC_COUNT_ZERO) begin
						nxt_active = 1'b0;
						nxt_hold_cnt = MC_COUNT_ZERO;
					end else begin
						nxt_hold_cnt = hold_cnt_ff - 2'h1;
					end
				end
			end
		end
	end

	// Registers only.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_ff <= PHASE_FIRST;
			high_cnt_ff <= MC_COUNT_ZERO;
			hold_cnt_ff <= MC_COUNT_ZERO;
			active_ff <= 1'b0;
		end else begin
			phase_ff <= nxt_phase;
			high_cnt_ff <= nxt_high_cnt;
			hold_cnt_ff <= nxt_hold_cnt;
			active_ff <= nxt_active;
		end
	end

	assign seq.fourth_clock_state = at_fourth;
	assign seq.ext_rst_active = active_ff;
	assign seq.phase = phase_ff;

endmodule : cimc_cycle_timer

// *** src/cimc_idle_ctrl.sv ***
// Behaviour
// RL1: Writing one to idle_request_bit enters idle.
// RL2: Setting instruction completes last before idle.
// RL3: CPU clock stops; peripheral clocks keep running.
// RL4: CPU registers hold contents while idle.
// RL5: ALE and program_store_strobe held high.
// RL6: Port pins keep levels from idle entry.
// RL7: Enabled interrupt clears bit, wakes, runs ISR.
// RL8: After ISR, resume after idle instruction.
// RL9: Reset pin, power-on or watchdog ends idle.
// RL10: Reset pin held two machine cycles minimum.
// RL11: Reset loads PC 0000h, SFRs reset.
// RL12: Execution starts at once after reset exit.
// RL13: Watchdog counts in idle; time-out interrupt wakes.
// RL14: Uncleared time-out gives reset 512 clocks later.
// RL15: Reset exit skips instruction after idle one.
// RL16: Machine cycle is four consecutive clock states.
// RL17: Reset pin sampled once, in fourth_clock_state.
// RL18: Any reset ending idle clears idle bit.
module cimc_idle_ctrl
	import cimc_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic idle_write,
	input wire logic irq_active,
	input wire logic por_in,
	input wire logic ext_reset_pin,
	input wire logic wdt_timeout,
	input wire logic wdt_clear,
	input wire logic wdt_int_en,
	input wire logic wdt_reset_en,
	input wire logic ale_in,
	input wire logic program_store_strobe_in,
	input wire logic [7:0] port_drive_in,
	output logic idle_request_bit_ff,
	output logic cpu_clk_en_ff,
	output logic periph_clk_en_ff,
	output logic ale_ff,
	output logic program_store_strobe_ff,
	output logic [7:0] port_out_ff,
	output logic core_reset_ff,
	output logic [15:0] pc_reset_value_ff,
	output logic isr_entry_ff,
	output logic wdt_irq_ff,
	output logic wdt_reset_flag_ff,
	output logic fourth_clock_state_ff
);

	// ----------------------------------------------------------------
	// Machine cycle timer and external reset qualifier
	// ----------------------------------------------------------------
	cimc_seq_if seq ();

	cimc_cycle_timer u_timer (
		.core_clk(core_clk),
		.srst(srst),
		.ext_reset_pin(ext_reset_pin),
		.seq(seq.timing)
	);

	// ----------------------------------------------------------------
	// Watchdog reset delay and hold
	// ----------------------------------------------------------------
	logic wdt_pending_ff;
	logic nxt_wdt_pending;
	logic [9:0] wdt_delay_ff;
	logic [9:0] nxt_wdt_delay;
	logic [3:0] wdt_hold_ff;
	logic [3:0] nxt_wdt_hold;
	logic wdt_rst_ff;
	logic nxt_wdt_rst;
	logic wdt_irq_set;

	// A time-out starts a 512-clock countdown; a clear cancels it, else reset fires.
	always_comb begin
		nxt_wdt_pending = wdt_pending_ff;
		nxt_wdt_delay = wdt_delay_ff;
		nxt_wdt_hold = wdt_hold_ff;
		nxt_wdt_rst = wdt_rst_ff;
		wdt_irq_set = wdt_timeout && wdt_int_en; // RL13
		if (wdt_rst_ff) begin
			// Reset is kept applied for two machine cycles.
			if (wdt_hold_ff == WDT_HOLD_ZERO) begin
				nxt_wdt_rst = 1'b0;
			end else begin
				nxt_wdt_hold = wdt_hold_ff - 4'h1;
			end
		end
		if (wdt_clear) begin
			nxt_wdt_pending = 1'b0;
			nxt_wdt_delay = WDT_DELAY_ZERO;
		end else if (wdt_timeout && !wdt_pending_ff) begin
			nxt_wdt_pending = 1'b1; // RL14
			nxt_wdt_delay = WDT_DELAY_LOAD;
		end else if (wdt_pending_ff) begin
			if (wdt_delay_ff == WDT_DELAY_ZERO) begin
				nxt_wdt_pending = 1'b0;
				if (wdt_reset_en) begin
					nxt_wdt_rst = 1'b1; // RL14
					nxt_wdt_hold = WDT_HOLD_LOAD;
				end
			end else begin
				nxt_wdt_delay = wdt_delay_ff - 10'h001;
			end
		end
	end

	// Registers only.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wdt_pending_ff <= 1'b0;
			wdt_delay_ff <= WDT_DELAY_ZERO;
			wdt_hold_ff <= WDT_HOLD_ZERO;
			wdt_rst_ff <= 1'b0;
		end else begin
			wdt_pending_ff <= nxt_wdt_pending;
			wdt_delay_ff <= nxt_wdt_delay;
			wdt_hold_ff <= nxt_wdt_hold;
			wdt_rst_ff <= nxt_wdt_rst;
		end
	end

	// ----------------------------------------------------------------
	// Idle state machine
	// ----------------------------------------------------------------
	cimc_state_t state_ff;
	cimc_state_t nxt_state;
	logic nxt_idle_bit;
	logic nxt_isr_entry;
	logic any_reset;
	logic wake_irq;

	// Any reset source ends idle and clears the request bit.
	always_comb begin
		any_reset = por_in || seq.ext_rst_active || wdt_rst_ff; // RL9
		wake_irq = irq_active || wdt_irq_set; // RL7 RL13
		nxt_state = state_ff;
		nxt_idle_bit = idle_request_bit_ff;
		nxt_isr_entry = 1'b0;
		case (state_ff)
			CIMC_RUN: begin
				// The write is the last retired instruction; next cycle is idle.
				if (idle_write && !any_reset) begin
					nxt_state = CIMC_IDLE; // RL1 RL2
					nxt_idle_bit = 1'b1; // RL1
				end
			end
			CIMC_IDLE: begin
				if (wake_irq && !any_reset) begin
					nxt_state = CIMC_RUN; // RL7
					nxt_idle_bit = 1'b0; // RL7
					nxt_isr_entry = 1'b1; // RL7 RL8
				end
			end
			default: begin
				nxt_state = CIMC_RUN;
				nxt_idle_bit = 1'b0;
			end
		endcase
		if (any_reset) begin
			nxt_state = CIMC_RUN; // RL9
			nxt_idle_bit = 1'b0; // RL18
			nxt_isr_entry = 1'b0;
		end
	end

	// Registers only.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			state_ff <= CIMC_RUN;
			idle_request_bit_ff <= 1'b0;
			isr_entry_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			idle_request_bit_ff <= nxt_idle_bit;
			isr_entry_ff <= nxt_isr_entry;
		end
	end

	// ----------------------------------------------------------------
	// Clock gates, pins and reset outputs
	// ----------------------------------------------------------------
	logic nxt_cpu_clk_en;
	logic nxt_ale;
	logic nxt_pss;
	logic [7:0] nxt_port_out;
	logic nxt_core_reset;
	logic nxt_wdt_irq;
	logic nxt_wdt_flag;

	// Idle freezes the CPU clock so its registers hold; port pins freeze at entry value, strobes go high.
	always_comb begin
		nxt_cpu_clk_en = (nxt_state == CIMC_RUN); // RL3 RL4
		nxt_core_reset = any_reset; // RL11 RL15
		nxt_wdt_irq = wdt_irq_set;
		nxt_wdt_flag = wdt_reset_flag_ff || wdt_rst_ff;
		if (wdt_rst_ff) begin
			nxt_wdt_flag = 1'b1;
		end else if (por_in) begin
			nxt_wdt_flag = 1'b0;
		end
		if (any_reset) begin
			// Pins go to reset levels; the CPU clock runs so start is immediate.
			nxt_ale = STROBE_IDLE_LEVEL;
			nxt_pss = STROBE_IDLE_LEVEL;
			nxt_port_out = PORT_RESET_VALUE;
			nxt_cpu_clk_en = 1'b1; // RL12
		end else if (nxt_state == CIMC_IDLE) begin
			nxt_ale = STROBE_IDLE_LEVEL; // RL5
			nxt_pss = STROBE_IDLE_LEVEL; // RL5
			// Entry cycle still samples the last driven value, then it holds.
			nxt_port_out = (state_ff == CIMC_RUN) ? port_drive_in : port_out_ff; // RL6
		end else begin
			nxt_ale = ale_in;
			nxt_pss = program_store_strobe_in;
			nxt_port_out = port_drive_in;
		end
	end

	// Registers only.
	always_ff @(posedge core_clk) begin
		if (srst) begin
			cpu_clk_en_ff <= 1'b1;
			periph_clk_en_ff <= 1'b1;
			ale_ff <= STROBE_IDLE_LEVEL;
			program_store_strobe_ff <= STROBE_IDLE_LEVEL;
			port_out_ff <= PORT_RESET_VALUE;
			core_reset_ff <= 1'b1;
			pc_reset_value_ff <= PC_RESET_VECTOR;
			wdt_irq_ff <= 1'b0;
			wdt_reset_flag_ff <= 1'b0;
			fourth_clock_state_ff <= 1'b0;
		end else begin
			cpu_clk_en_ff <= nxt_cpu_clk_en;
			periph_clk_en_ff <= 1'b1; // RL3
			ale_ff <= nxt_ale;
			program_store_strobe_ff <= nxt_pss;
			port_out_ff <= nxt_port_out;
			core_reset_ff <= nxt_core_reset;
			pc_reset_value_ff <= PC_RESET_VECTOR; // RL11
			wdt_irq_ff <= nxt_wdt_irq;
			wdt_reset_flag_ff <= nxt_wdt_flag;
			fourth_clock_state_ff <= seq.fourth_clock_state;
		end
	end

endmodule : cimc_idle_ctrl

// *** testbench/cimc_idle_asserts.sv ***
module cimc_idle_asserts
	import cimc_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic idle_write,
	input wire logic irq_active,
	input wire logic por_in,
	input wire logic ext_reset_pin,
	input wire logic wdt_timeout,
	input wire logic wdt_int_en,
	input wire logic [7:0] port_drive_in,
	input wire logic idle_request_bit_ff,
	input wire logic cpu_clk_en_ff,
	input wire logic periph_clk_en_ff,
	input wire logic ale_ff,
	input wire logic program_store_strobe_ff,
	input wire logic [7:0] port_out_ff,
	input wire logic core_reset_ff,
	input wire logic [15:0] pc_reset_value_ff,
	input wire logic isr_entry_ff,
	input wire logic wdt_irq_ff,
	input wire logic wdt_reset_flag_ff,
	input wire logic fourth_clock_state_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Idle entry, hold and exit checks
	// ----
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	logic calm;
	// No reset source is visibly pending in this cycle.
	assign calm = !por_in && !ext_reset_pin && !core_reset_ff;
	idle_entry_a: assert property (
		idle_write && !idle_request_bit_ff && calm |=> idle_request_bit_ff && port_out_ff == $past(port_drive_in))
		else $error("idle entry missed");
	strobe_high_a: assert property (
		idle_request_bit_ff |-> ale_ff && program_store_strobe_ff) else $error("strobes not high in idle");
	clock_gate_a: assert property (
		idle_request_bit_ff |-> !cpu_clk_en_ff && periph_clk_en_ff) else $error("clock gating wrong in idle");
	port_hold_a: assert property (
		idle_request_bit_ff && $past(idle_request_bit_ff) |-> $stable(port_out_ff)) else $error("port moved in idle");
	irq_wake_a: assert property (
		idle_request_bit_ff && irq_active && calm |=> !idle_request_bit_ff && cpu_clk_en_ff && isr_entry_ff
		##1 !isr_entry_ff) else $error("interrupt wake wrong");
	por_exit_a: assert property (
		por_in |=> core_reset_ff && !idle_request_bit_ff && pc_reset_value_ff == PC_RESET_VECTOR
		&& !wdt_reset_flag_ff) else $error("power-on exit wrong");
	reset_run_a: assert property (
		core_reset_ff |-> !idle_request_bit_ff && cpu_clk_en_ff && !isr_entry_ff) else $error("reset left idle on");
	cycle_len_a: assert property (
		fourth_clock_state_ff |=> !fourth_clock_state_ff [*3] ##1 fourth_clock_state_ff)
		else $error("machine cycle not four clocks");
	wdt_wake_a: assert property (
		wdt_timeout && wdt_int_en && calm |=> wdt_irq_ff && !idle_request_bit_ff) else $error("watchdog wake wrong");
	// Main scenarios reached.
	cover property (idle_request_bit_ff && irq_active);
	cover property (idle_request_bit_ff && por_in);
	cover property ($rose(wdt_reset_flag_ff));
endmodule : cimc_idle_asserts

bind cimc_idle_ctrl cimc_idle_asserts chk_u (.core_clk(core_clk), .srst(srst), .idle_write(idle_write),
	.irq_active(irq_active), .por_in(por_in), .ext_reset_pin(ext_reset_pin), .wdt_timeout(wdt_timeout),
	.wdt_int_en(wdt_int_en), .port_drive_in(port_drive_in), .idle_request_bit_ff(idle_request_bit_ff),
	.cpu_clk_en_ff(cpu_clk_en_ff), .periph_clk_en_ff(periph_clk_en_ff), .ale_ff(ale_ff),
	.program_store_strobe_ff(program_store_strobe_ff), .port_out_ff(port_out_ff), .core_reset_ff(core_reset_ff),
	.pc_reset_value_ff(pc_reset_value_ff), .isr_entry_ff(isr_entry_ff), .wdt_irq_ff(wdt_irq_ff),
	.wdt_reset_flag_ff(wdt_reset_flag_ff), .fourth_clock_state_ff(fourth_clock_state_ff));

// *** testbench/cimc_far_model.sv ***
module cimc_far_model (
	input wire logic core_clk,
	output logic irq_active,
	output logic por_in,
	output logic ext_reset_pin,
	output logic wdt_timeout,
	output logic wdt_clear
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Interrupt, watchdog and reset pin stand-in
	// ----
	// All sources start quiet.
	initial begin
		{irq_active, por_in, ext_reset_pin, wdt_timeout, wdt_clear} = 5'h00;
	end
	// Raises the chosen sources on a falling edge for n cycles.
	task automatic drive(input logic [4:0] v, input int n);
		@(negedge core_clk);
		{irq_active, por_in, ext_reset_pin, wdt_timeout, wdt_clear} = v;
		repeat (n) @(negedge core_clk);
		{irq_active, por_in, ext_reset_pin, wdt_timeout, wdt_clear} = 5'h00;
	endtask : drive
	// Holds the reset pin; under eight clocks only when a glitch is wanted.
	task automatic ext_rst(input int n);
		drive(5'h04, n);
	endtask : ext_rst
endmodule : cimc_far_model

// *** testbench/cpu_idle_mode_control_tb_top.sv ***
module cpu_idle_mode_control_tb_top import cimc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'h0;
	logic srst = 1'h1;
	logic idle_write = 1'h0;
	logic wdt_int_en = 1'h0;
	logic wdt_reset_en = 1'h0;
	logic ale_in = 1'h0;
	logic pss_in = 1'h0;
	logic [7:0] port_drive_in = 8'h00;
	logic irq_active, por_in, ext_reset_pin, wdt_timeout, wdt_clear;
	logic idle_bit, cpu_en, ale, pss, core_rst, isr, wdt_flag, isr_seen, rst_seen;
	logic [7:0] port_out;
	logic [15:0] pc_rst;
	logic [7:0] p;
	int m, n;
	int bad_count = 0;
	int n_compared = 0;
	// ----
	// Clock, device and far side
	// ----
	always #2 core_clk = ~core_clk;
	cimc_far_model fm (.core_clk(core_clk), .irq_active(irq_active), .por_in(por_in),
		.ext_reset_pin(ext_reset_pin), .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear));
	cimc_idle_ctrl dut_u (.core_clk(core_clk), .srst(srst), .idle_write(idle_write), .irq_active(irq_active),
		.por_in(por_in), .ext_reset_pin(ext_reset_pin), .wdt_timeout(wdt_timeout), .wdt_clear(wdt_clear),
		.wdt_int_en(wdt_int_en), .wdt_reset_en(wdt_reset_en), .ale_in(ale_in), .program_store_strobe_in(pss_in),
		.port_drive_in(port_drive_in), .idle_request_bit_ff(idle_bit), .cpu_clk_en_ff(cpu_en),
		.periph_clk_en_ff(), .ale_ff(ale), .program_store_strobe_ff(pss), .port_out_ff(port_out),
		.core_reset_ff(core_rst), .pc_reset_value_ff(pc_rst), .isr_entry_ff(isr), .wdt_irq_ff(),
		.wdt_reset_flag_ff(wdt_flag), .fourth_clock_state_ff());
	// Latches wake and reset events between checks.
	always @(posedge core_clk) begin
		if (isr === 1'h1) isr_seen <= 1'h1;
		if (core_rst === 1'h1) rst_seen <= 1'h1;
	end
	function automatic logic [11:0] exp_entry(input logic [7:0] v);
		return {4'hb, v};
	endfunction : exp_entry
	// Only interrupt wakes run the service routine.
	function automatic logic exp_isr(input int k);
		return k != 2 && k != 3;
	endfunction : exp_isr
	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask : cyc
	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Retires the idle write with a known port value, then moves the core drive.
	task automatic enter(input logic [7:0] v);
		@(negedge core_clk);
		idle_write = 1'h1;
		port_drive_in = v;
		{ale_in, pss_in} = 2'($urandom);
		@(negedge core_clk);
		idle_write = 1'h0;
		port_drive_in = ~v;
		{ale_in, pss_in} = 2'h0;
		chk({idle_bit, cpu_en, ale, pss, port_out}, exp_entry(v));
	endtask : enter
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done
	// ----
	// Tests
	// ----
	// Idle entry and each way out, then the watchdog reset path.
	initial begin
		void'($urandom(61));
		cyc(5);
		srst = 1'h0;
		for (int i = 0; i < 10; i++) begin
			m = i % 5;
			p = 8'($urandom);
			isr_seen = 1'h0;
			enter(p);
			cyc(3);
			chk({idle_bit, port_out}, {1'h1, p});
			wdt_int_en = (m == 1);
			case (m)
				0: fm.drive(5'h10, 2);
				1: begin
					fm.drive(5'h02, 1);
					fm.drive(5'h01, 1);
				end
				2: fm.drive(5'h08, 2);
				3: fm.ext_rst(8 + $urandom % 8);
				default: begin
					fm.ext_rst(4);
					chk(idle_bit, 1'h1);
					fm.drive(5'h10, 2);
				end
			endcase
			cyc(20);
			chk({idle_bit, cpu_en, isr_seen, pc_rst}, {2'h1, exp_isr(m), PC_RESET_VECTOR});
			{ale_in, pss_in} = 2'($urandom);
			cyc(1);
			chk({ale, pss}, {ale_in, pss_in});
			$display("test %0d done", i);
		end
		enter(8'h5a);
		wdt_int_en = 1'h0;
		wdt_reset_en = 1'h1;
		fm.drive(5'h02, 1);
		n = 0;
		while (core_rst !== 1'h1 && n < 600) begin
			cyc(1);
			n++;
		end
		chk(n >= 512 && n <= 515, 1'h1);
		cyc(20);
		chk({idle_bit, cpu_en, wdt_flag}, 3'h3);
		enter(8'ha5);
		rst_seen = 1'h0;
		fm.drive(5'h02, 1);
		cyc(100);
		fm.drive(5'h01, 1);
		cyc(600);
		chk({rst_seen, idle_bit}, 2'h1);
		fm.drive(5'h08, 2);
		cyc(10);
		chk(wdt_flag, 1'h0);
		$display("watchdog tests done");
		test_done();
	end
	// Cuts a hang short well past the expected run length.
	initial begin
		cyc(5000);
		bad_count++;
		test_done();
	end
endmodule : cpu_idle_mode_control_tb_top
